// ### rtl/data_move_instruction_exec.v
// Executes the four data-move instructions over a four-quarter cycle
`timescale 1ns/1ps
`include "data_move_defines.vh"
module data_move_instruction_exec (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        arst_n,
	// Avalon-MM slave
	input  wire [4:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest
);
	localparam ST_IDLE  = 2'h0;
	localparam ST_EXEC  = 2'h1;
	localparam ST_MEMRD = 2'h2;
	localparam ST_MEMCP = 2'h3;

	reg  [1:0]  state;
	reg  [1:0]  quarter;
	reg  [15:0] instr;
	reg  [7:0]  working;
	reg  [3:0]  bank_select_register;
	reg         extended;
	reg  [11:0] index_base;
	reg  [11:0] mem_addr;
	reg  [4:0]  status_flags;
	reg         pending;
	reg  [7:0]  src_byte;
	wire [7:0]  mem_rdata;

	reg         next_we;
	reg  [11:0] next_waddr;
	reg  [7:0]  next_wdata;
	reg  [11:0] read_addr;
	reg  [11:0] file_addr;
	reg  [31:0] next_readdata;
	reg  [7:0]  next_working;
	reg  [3:0]  next_bank_select_register;

	// Instruction decode
	wire [7:0]  f_field = instr[7:0];
	wire        access  = instr[`ACCESS_BIT];
	wire is_first   = (instr[15:12] == `OP_FILE_FIRST) && !pending;
	wire is_second  = pending;
	wire is_lit_bsr = (instr[15:8] == `OP_LIT_BANK) && !pending;
	wire is_lit_w   = (instr[15:8] == `OP_LIT_WORKING) && !pending;
	wire is_w_file  = (instr[15:9] == `OP_WORKING_FILE) && !pending;
	wire second_ok  = (instr[15:12] == `OP_FILE_SECOND);
	wire reg_req    = (avs_read || avs_write) && avs_waitrequest;

	// Effective address of a banked operand
	always @* begin
		if (access) begin
			file_addr = {bank_select_register, f_field};
		end else if (extended && (f_field <= `INDEXED_MAX)) begin
			file_addr = index_base + {4'h0, f_field};
		end else if (f_field < `ACCESS_SPLIT) begin
			file_addr = {4'h0, f_field};
		end else begin
			file_addr = {`ACCESS_HIGH_BANK, f_field};
		end
	end

	// Memory read address and Q4 write selection
	always @* begin
		read_addr  = (state == ST_MEMRD || state == ST_MEMCP) ? mem_addr : instr[11:0];
		next_we    = 1'b0;
		next_waddr = mem_addr;
		next_wdata = avs_writedata[7:0];
		if (state == ST_IDLE && avs_write && avs_waitrequest
			&& avs_address == `OFS_MEM_DATA) begin
			next_we = 1'b1;
		end else if (state == ST_EXEC && quarter == `Q_LAST) begin
			if (is_w_file && file_addr != `WORKING_ADDR) begin
				next_we    = 1'b1;
				next_waddr = file_addr;
				next_wdata = working;
			end else if (is_second && second_ok && instr[11:0] != `WORKING_ADDR) begin
				next_we    = 1'b1;
				next_waddr = instr[11:0];
				next_wdata = src_byte;
			end
		end
	end

	// Read data of the registers answered in one cycle
	always @* begin
		next_readdata = 32'h0000_0000;
		case (avs_address)
		`OFS_WORKING: begin
			next_readdata[7:0] = working;
		end
		`OFS_BANK_SELECT: begin
			next_readdata[3:0] = bank_select_register;
		end
		`OFS_CONFIG: begin
			next_readdata[`CFG_EXTENDED_BIT] = extended;
		end
		`OFS_INDEX_BASE: begin
			next_readdata[11:0] = index_base;
		end
		`OFS_MEM_ADDR: begin
			next_readdata[11:0] = mem_addr;
		end
		`OFS_STATUS: begin
			next_readdata[4:0]                 = status_flags;
			next_readdata[`STATUS_PENDING_BIT] = pending;
		end
		default: begin
			next_readdata = 32'h0000_0000;
		end
		endcase
	end

	// Working and bank select values taken in the fourth quarter
	always @* begin
		next_working              = working;
		next_bank_select_register = bank_select_register;
		if (is_lit_w) begin
			next_working = f_field;
		end
		if (is_lit_bsr) begin
			next_bank_select_register = f_field[3:0];
		end
		if (is_second && second_ok && instr[11:0] == `WORKING_ADDR) begin
			next_working = src_byte;
		end
	end

	data_memory #(
		.AW (12),
		.DW (8)
	) u_mem (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.we      (next_we),
		.waddr   (next_waddr),
		.wdata   (next_wdata),
		.raddr   (read_addr),
		.rdata   (mem_rdata)
	);

	// Bus handshake, instruction quarters and memory read sequencing
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state                <= ST_IDLE;
			quarter              <= 2'h0;
			instr                <= 16'h0000;
			working              <= `RST_WORKING;
			bank_select_register <= `RST_BANK_SELECT;
			extended             <= 1'b0;
			index_base           <= `RST_INDEX_BASE;
			mem_addr             <= 12'h000;
			status_flags         <= `RST_STATUS;
			pending              <= 1'b0;
			src_byte             <= 8'h00;
			avs_readdata         <= 32'h0000_0000;
			avs_waitrequest      <= 1'b1;
		end else begin
			avs_waitrequest <= 1'b1;
			case (state)
			ST_IDLE: begin
				if (reg_req && avs_write) begin
					case (avs_address)
					`OFS_INSTRUCTION: begin
						instr   <= avs_writedata[15:0];
						quarter <= 2'h0;
						state   <= ST_EXEC;
					end
					`OFS_WORKING:     working <= avs_writedata[7:0];
					`OFS_BANK_SELECT: bank_select_register <= avs_writedata[3:0];
					`OFS_CONFIG:      extended <= avs_writedata[`CFG_EXTENDED_BIT];
					`OFS_INDEX_BASE:  index_base <= avs_writedata[11:0];
					`OFS_MEM_ADDR:    mem_addr <= avs_writedata[11:0];
					`OFS_STATUS:      status_flags <= avs_writedata[4:0];
					default: begin
					end
					endcase
					if (avs_address != `OFS_INSTRUCTION) begin
						avs_waitrequest <= 1'b0;
					end
				end else if (reg_req && avs_read) begin
					avs_readdata <= next_readdata;
					if (avs_address == `OFS_MEM_DATA) begin
						state <= ST_MEMRD;
					end else begin
						avs_waitrequest <= 1'b0;
					end
				end
			end
			ST_EXEC: begin
				quarter <= quarter + 2'h1;
				// Source byte is valid from the registered read one quarter after Q2
				if (quarter == `Q_LATCH && is_first) begin
					src_byte <= (instr[11:0] == `WORKING_ADDR) ? working : mem_rdata;
				end
				if (quarter == `Q_LAST) begin
					working              <= next_working;
					bank_select_register <= next_bank_select_register;
					pending         <= is_first;
					avs_waitrequest <= 1'b0;
					state           <= ST_IDLE;
				end
			end
			ST_MEMRD: begin
				state <= ST_MEMCP;
			end
			ST_MEMCP: begin
				avs_readdata    <= {24'h00_0000, mem_rdata};
				avs_waitrequest <= 1'b0;
				state           <= ST_IDLE;
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end
	// Status flags are written only by software
endmodule

// ### rtl/data_move_defines.vh
// Constants for the data-move instruction execution block
// Overview of operation
// - File-to-file move takes 12-bit source and destination covering 000h to FFFh.
// - File-to-file move also works when either operand is the working register.
// - File-to-file move: two words, two cycles, read first cycle Q2, write second Q4.
// - Literal-to-bank-select loads only the low nibble; upper four bits stay zero.
// - Literal-to-working loads the 8-bit literal into working register in Q4.
// - Working-to-file copies working register into the bank location, one cycle.
// - Access bit zero picks access bank; one picks bank from bank select register.
// - Extended set, access bit zero, address up to 5Fh: indexed literal offset.
`ifndef DATA_MOVE_DEFINES_VH
`define DATA_MOVE_DEFINES_VH

// Register byte offsets
`define OFS_INSTRUCTION   5'h00
`define OFS_WORKING       5'h04
`define OFS_BANK_SELECT   5'h08
`define OFS_CONFIG        5'h0C
`define OFS_INDEX_BASE    5'h10
`define OFS_MEM_ADDR      5'h14
`define OFS_MEM_DATA      5'h18
`define OFS_STATUS        5'h1C

// Reset values
`define RST_WORKING       8'h00
`define RST_BANK_SELECT   4'h0
`define RST_INDEX_BASE    12'h000
`define RST_STATUS        5'h00

// Field positions
`define CFG_EXTENDED_BIT  0
`define STATUS_PENDING_BIT 8
`define ACCESS_BIT        8

// Opcodes
`define OP_FILE_FIRST     4'hC
`define OP_FILE_SECOND    4'hF
`define OP_LIT_BANK       8'h01
`define OP_LIT_WORKING    8'h0E
`define OP_WORKING_FILE   7'h37

// Data space
`define WORKING_ADDR      12'hFE8
`define ACCESS_SPLIT      8'h60
`define INDEXED_MAX       8'h5F
`define ACCESS_HIGH_BANK  4'hF

// Quarters per instruction cycle
`define Q_LAST            2'h3
`define Q_READ            2'h1
`define Q_LATCH           2'h2

`endif

// ### rtl/data_memory.v
// Byte-wide data space with registered read port
`timescale 1ns/1ps
module data_memory #(
	parameter AW = 12,
	parameter DW = 8
) (
	// Clock and reset
	input  wire          ref_clk,
	input  wire          arst_n,
	// Write port
	input  wire          we,
	input  wire [AW-1:0] waddr,
	input  wire [DW-1:0] wdata,
	// Read port
	input  wire [AW-1:0] raddr,
	output reg  [DW-1:0] rdata
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge ref_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= {DW{1'b0}};
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule

// ### bench/data_move_asserts.sv
// Bus timing and read-data upper-bit checks for the data-move block
`timescale 1ns/1ps
module data_move_asserts (
	// Clock and reset
	input wire        ref_clk,
	input wire        arst_n,
	// Bus
	input wire [4:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest
);
	reg        held;
	wire       wt = avs_waitrequest;
	wire [4:0] ad = avs_address;
	wire       tk = (avs_read | avs_write) & wt & !held;
	wire       rk = avs_read & !wt;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// Marks cycles where a taken request is still waiting
	always @(posedge ref_clk or negedge arst_n)
		if (!arst_n) held <= 1'b0;
		else held <= (avs_read | avs_write) & wt;
	property p_ins; tk && avs_write && ad == 5'h00 |=> wt [*4] ##1 !wt; endproperty
	a_ins: assert property (p_ins) else $error("op timing");
	property p_reg; tk && ad != 5'h00 && ad != 5'h18 |=> !wt; endproperty
	a_reg: assert property (p_reg) else $error("reg timing");
	property p_mrd; tk && avs_read && ad == 5'h18 |=> wt ##1 wt ##1 !wt; endproperty
	a_mrd: assert property (p_mrd) else $error("mem timing");
	property p_one; !wt |=> wt; endproperty
	a_one: assert property (p_one) else $error("ack held");
	property p_idl; !(avs_read | avs_write) |=> wt; endproperty
	a_idl: assert property (p_idl) else $error("stray ack");
	property p_bsr; rk && ad == 5'h08 |-> avs_readdata[31:4] == 28'h0; endproperty
	a_bsr: assert property (p_bsr) else $error("bank high");
	property p_wrk; rk && ad == 5'h04 |-> avs_readdata[31:8] == 24'h0; endproperty
	a_wrk: assert property (p_wrk) else $error("work high");
	property p_st; rk && ad == 5'h1C |-> avs_readdata[31:9] == 23'h0; endproperty
	a_st: assert property (p_st) else $error("status high");
endmodule
bind data_move_instruction_exec data_move_asserts data_move_asserts_inst (.ref_clk, .arst_n,
	.avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest);

// ### bench/tb_top.sv
// Random and corner tests for the data-move block
`timescale 1ns/1ps
module tb_top;
	reg         ref_clk = 0;
	reg         arst_n = 0;
	reg  [4:0]  ad = 0;
	reg         rd = 0;
	reg         we = 0;
	reg  [31:0] wd = 0;
	wire [31:0] q;
	wire        wt;
	reg  [31:0] v;
	reg  [16:0] s = 17'h15AFF;
	reg  [11:0] ib;
	reg  [7:0]  f;
	integer     num_errors = 0;
	integer     comparisons = 0;
	integer     i;
	always #10 ref_clk = ~ref_clk;
	data_move_instruction_exec data_move_instruction_exec_inst (.ref_clk(ref_clk),
		.arst_n(arst_n), .avs_address(ad), .avs_read(rd), .avs_write(we),
		.avs_writedata(wd), .avs_readdata(q), .avs_waitrequest(wt));
	task bus(input r, input [4:0] a, input [31:0] d);
		begin
			rd <= r;
			we <= !r;
			ad <= a;
			wd <= d;
			@(posedge ref_clk);
			while (wt !== 1'b0) @(posedge ref_clk);
			v = q;
			rd <= 0;
			we <= 0;
			@(posedge ref_clk);
		end
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			comparisons = comparisons + 1;
			if (seen !== exp) begin
				num_errors = num_errors + 1;
				$display("MISMATCH offset %h exp %h seen %h", ad, exp, seen);
			end
		end
	endtask
	task rc(input [4:0] a, input [31:0] e);
		begin
			bus(1, a, 0);
			chk(v, e);
		end
	endtask
	task test_done;
		begin
			$display("comparisons %0d num_errors %0d", comparisons, num_errors);
			if (num_errors == 0 && comparisons > 0) $display("Regression OK");
			else $display("Regression broken");
			$finish;
		end
	endtask
	// Effective address of a working-to-file store
	function [11:0] ea(input a, input x, input [7:0] f, input [3:0] b);
		ea = a ? {b, f} : (x && f < 8'h60) ? ib + f : {{4{f > 8'h5F}}, f};
	endfunction
	// Next state of the stimulus shift register
	function [16:0] lfsr_next(input [16:0] cur);
		lfsr_next = {cur[15:0], cur[16] ^ cur[13]};
	endfunction
	initial begin
		#100000;
		num_errors = num_errors + 1;
		test_done;
	end
	initial begin
		repeat (4) @(posedge ref_clk);
		arst_n <= 1;
		@(posedge ref_clk);
		rc(5'h08, 0);
		for (i = 0; i < 24; i = i + 1) begin
			s = lfsr_next(s);
			// Odd offsets keep clear of the working register alias
			f = i[0] ? 8'h5F + i[1] : s[16:9] | 8'h01;
			ib = {4'h1, s[7:0]};
			bus(0, 5'h0C, i[3]);
			bus(0, 5'h10, ib);
			bus(0, 5'h1C, s[4:0]);
			bus(0, 5'h00, {8'h01, 4'hA, s[11:8]});
			rc(5'h08, s[11:8]);
			bus(0, 5'h00, {8'h0E, s[7:0]});
			rc(5'h04, s[7:0]);
			bus(0, 5'h00, {7'h37, i[2], f});
			rc(5'h04, s[7:0]);
			bus(0, 5'h14, ea(i[2], i[3], f, s[11:8]));
			rc(5'h18, s[7:0]);
			rc(5'h1C, s[4:0]);
			rc(5'h0C, i[3]);
			rc(5'h10, ib);
		end
		bus(0, 5'h1C, 0);
		bus(0, 5'h14, 12'h000);
		bus(0, 5'h18, 8'h33);
		bus(0, 5'h00, 16'hC000);
		rc(5'h1C, 32'h100);
		bus(0, 5'h00, 16'hFFFF);
		bus(0, 5'h14, 12'hFFF);
		rc(5'h18, 8'h33);
		bus(0, 5'h00, 16'hCFE8);
		bus(0, 5'h00, 16'hF123);
		bus(0, 5'h14, 12'h123);
		rc(5'h18, s[7:0]);
		bus(0, 5'h00, 16'hC000);
		bus(0, 5'h00, 16'hFFE8);
		rc(5'h04, 8'h33);
		rc(5'h1C, 0);
		test_done;
	end
endmodule
